//--- logic/spm_cfg.svh
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_MODE_CTRL_ADDR 14'h2015
`define SPM_SYS_CTRL_ADDR 14'h3fff
`define SPM_MODE_CTRL_W 9
`define SPM_SYS_CTRL_W 16
`define SPM_RX_SEL_BIT 4
`define SPM_UART_BIT 5
`define SPM_ALT_BIT 10
`define SPM_MODE_CTRL_RST 9'h000
`define SPM_SYS_CTRL_RST 16'h0000
`endif

//--- logic/spm_pin_mux.sv
`timescale 1ns/1ps
`include "spm_cfg.svh"
module spm_pin_mux (
  spm_sel_if.mux sel,
  input wire logic receive_pin_a,
  input wire logic receive_pin_b,
  input wire logic receive_frame_sync_pin,
  input wire logic transmit_frame_sync_pin,
  input wire logic serial_bit_clock_pin,
  input wire logic serial_transmit_output,
  input wire logic core_flag_output,
  input wire logic sport_rfs_out,
  input wire logic sport_rfs_oe,
  input wire logic core_flag_out_pin_value,
  output logic serial_receive_input,
  output logic sport_rfs_in,
  output logic sport_tfs_in,
  output logic sport_clock_in,
  output logic flag_input_pin,
  output logic core_external_int_a,
  output logic core_external_int_b,
  output logic transmit_pin_out,
  output logic gpio5_frame_sync_out,
  output logic gpio5_frame_sync_oe,
  output logic gpio_a_free,
  output logic gpio_b_free
);
  import spm_pkg::*;
  logic rx_sel;
  always_comb begin
    rx_sel = sel.rx_pin_select ? receive_pin_b : receive_pin_a;
    serial_receive_input = sel.alt_config ? 1'b1 : rx_sel;
    flag_input_pin = sel.alt_config ? rx_sel : 1'b0;
    // Idle-high keeps the port quiet while its pins are borrowed
    sport_rfs_in = sel.uart_mode ? rx_sel : receive_frame_sync_pin;
    if (sel.alt_config) begin
      sport_rfs_in = 1'b1;
    end
    sport_tfs_in = sel.alt_config ? 1'b1 : transmit_frame_sync_pin;
    core_external_int_a = sel.alt_config ? receive_frame_sync_pin : 1'b1;
    core_external_int_b = sel.alt_config ? transmit_frame_sync_pin : 1'b1;
    sport_clock_in = serial_bit_clock_pin;
    transmit_pin_out = sel.alt_config ? core_flag_out_pin_value : serial_transmit_output;
    if (sel.uart_mode) begin
      gpio5_frame_sync_out = core_flag_output;
      gpio5_frame_sync_oe = 1'b1;
    end else begin
      gpio5_frame_sync_out = sport_rfs_out;
      gpio5_frame_sync_oe = sport_rfs_oe & ~sel.alt_config;
    end
    gpio_a_free = sel.rx_pin_select;
    gpio_b_free = ~sel.rx_pin_select;
  end
endmodule // spm_pin_mux

//--- logic/spm_pkg.sv
package spm_pkg;
  typedef logic [13:0] spm_addr_t;
  typedef logic [15:0] spm_data_t;
  typedef enum logic [2:0] {
    SPM_CFG_NORMAL = 3'h1,
    SPM_CFG_UART = 3'h2,
    SPM_CFG_ALT = 3'h4
  } spm_cfg_t;
endpackage

//--- logic/spm_sel_if.sv
`timescale 1ns/1ps
interface spm_sel_if;
  logic rx_pin_select;
  logic uart_mode;
  logic alt_config;
  modport ctrl (output rx_pin_select, output uart_mode, output alt_config);
  modport mux (input rx_pin_select, input uart_mode, input alt_config);
endinterface

//--- logic/spm_top.sv
`timescale 1ns/1ps
`include "spm_cfg.svh"
// Notes on behaviour
// - One of two receive pins feeds the single serial receive input.
// - Receive select bit set routes receive pin B to the port.
// - Receive select bit clear routes receive pin A to the port.
// - UART mode bit set puts serial port one in UART emulation.
// - In UART mode receive data also drives receive frame sync.
// - In UART mode the core flag output drives the shared GPIO5 pin.
// - Bit 10 of system control at 0x3fff selects the alternate configuration.
// - Alternate: selected receive pin is flag input, transmit pin is flag output.
// - Alternate: receive frame sync pin becomes first external interrupt.
// - Alternate: transmit frame sync pin becomes second external interrupt.
// - Serial clock pin keeps its clock function in every configuration.
// - The unselected receive pin stays free for general-purpose I/O.
module spm_top (
  input wire logic clock,
  input wire logic srst,
  input wire spm_pkg::spm_addr_t reg_addr,
  input wire spm_pkg::spm_data_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output spm_pkg::spm_data_t reg_rdata,
  input wire logic receive_pin_a,
  input wire logic receive_pin_b,
  input wire logic receive_frame_sync_pin,
  input wire logic transmit_frame_sync_pin,
  input wire logic serial_bit_clock_pin,
  input wire logic serial_transmit_output,
  input wire logic core_flag_output,
  input wire logic sport_rfs_out,
  input wire logic sport_rfs_oe,
  output logic serial_receive_input,
  output logic sport_rfs_in,
  output logic sport_tfs_in,
  output logic sport_clock_in,
  output logic flag_input_pin,
  output logic core_external_int_a,
  output logic core_external_int_b,
  output logic transmit_pin_out,
  output logic gpio5_frame_sync_out,
  output logic gpio5_frame_sync_oe,
  output logic gpio_a_free,
  output logic gpio_b_free,
  output spm_pkg::spm_cfg_t active_config
);
  import spm_pkg::*;
  logic [`SPM_MODE_CTRL_W-1:0] mode_ctrl_reg;
  logic [`SPM_MODE_CTRL_W-1:0] mode_ctrl_next;
  logic [`SPM_SYS_CTRL_W-1:0] sys_ctrl_reg;
  logic [`SPM_SYS_CTRL_W-1:0] sys_ctrl_next;
  spm_data_t rdata_reg;
  spm_data_t rdata_next;
  spm_sel_if sel ();

  always_comb begin
    mode_ctrl_next = mode_ctrl_reg;
    sys_ctrl_next = sys_ctrl_reg;
    rdata_next = 16'h0000;
    if (reg_write && reg_addr == `SPM_MODE_CTRL_ADDR) begin
      mode_ctrl_next = reg_wdata[`SPM_MODE_CTRL_W-1:0];
    end
    if (reg_write && reg_addr == `SPM_SYS_CTRL_ADDR) begin
      sys_ctrl_next = reg_wdata;
    end
    // Unmapped reads return zero; upper mode bits read as zero
    if (reg_read && reg_addr == `SPM_MODE_CTRL_ADDR) begin
      rdata_next = {7'h00, mode_ctrl_reg};
    end
    if (reg_read && reg_addr == `SPM_SYS_CTRL_ADDR) begin
      rdata_next = sys_ctrl_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_ctrl_reg <= `SPM_MODE_CTRL_RST;
      sys_ctrl_reg <= `SPM_SYS_CTRL_RST;
      rdata_reg <= 16'h0000;
    end else begin
      mode_ctrl_reg <= mode_ctrl_next;
      sys_ctrl_reg <= sys_ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sel.rx_pin_select = mode_ctrl_reg[`SPM_RX_SEL_BIT];
  assign sel.uart_mode = mode_ctrl_reg[`SPM_UART_BIT];
  assign sel.alt_config = sys_ctrl_reg[`SPM_ALT_BIT];

  always_comb begin
    // Alternate takes precedence here and for sport_rfs_in; UART mode still wins for GPIO5
    if (sel.alt_config) begin
      active_config = SPM_CFG_ALT;
    end else if (sel.uart_mode) begin
      active_config = SPM_CFG_UART;
    end else begin
      active_config = SPM_CFG_NORMAL;
    end
  end

  spm_pin_mux u_mux (
    .sel(sel),
    .receive_pin_a(receive_pin_a),
    .receive_pin_b(receive_pin_b),
    .receive_frame_sync_pin(receive_frame_sync_pin),
    .transmit_frame_sync_pin(transmit_frame_sync_pin),
    .serial_bit_clock_pin(serial_bit_clock_pin),
    .serial_transmit_output(serial_transmit_output),
    .core_flag_output(core_flag_output),
    .sport_rfs_out(sport_rfs_out),
    .sport_rfs_oe(sport_rfs_oe),
    .core_flag_out_pin_value(core_flag_output),
    .serial_receive_input(serial_receive_input),
    .sport_rfs_in(sport_rfs_in),
    .sport_tfs_in(sport_tfs_in),
    .sport_clock_in(sport_clock_in),
    .flag_input_pin(flag_input_pin),
    .core_external_int_a(core_external_int_a),
    .core_external_int_b(core_external_int_b),
    .transmit_pin_out(transmit_pin_out),
    .gpio5_frame_sync_out(gpio5_frame_sync_out),
    .gpio5_frame_sync_oe(gpio5_frame_sync_oe),
    .gpio_a_free(gpio_a_free),
    .gpio_b_free(gpio_b_free)
  );
endmodule // spm_top

//--- verification/spm_chk_sva.sv
`timescale 1ns/1ps
module spm_chk (
  input wire logic clock, srst, reg_write, receive_pin_a, receive_pin_b, core_flag_output,
  input wire logic receive_frame_sync_pin, transmit_frame_sync_pin, serial_bit_clock_pin,
  input wire logic serial_receive_input, sport_rfs_in, sport_clock_in, flag_input_pin,
  input wire logic core_external_int_a, core_external_int_b, transmit_pin_out,
  input wire logic gpio5_frame_sync_out, gpio5_frame_sync_oe, gpio_a_free,
  input wire spm_pkg::spm_addr_t reg_addr,
  input wire spm_pkg::spm_data_t reg_wdata,
  input wire spm_pkg::spm_cfg_t active_config
);
  import spm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic alt, sel, mw;
  assign alt = active_config == SPM_CFG_ALT;
  assign sel = gpio_a_free ? receive_pin_b : receive_pin_a;
  assign mw = reg_write && reg_addr == 14'h2015;
  property p_sel_wr; mw |=> gpio_a_free == $past(reg_wdata[4]); endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select bit not applied");
  property p_alt_wr; reg_write && reg_addr == 14'h3fff |=> alt == $past(reg_wdata[10]); endproperty
  a_alt_wr: assert property (p_alt_wr) else $error("alternate bit not applied");
  property p_mode; mw && reg_wdata[5] && !alt |=> active_config == SPM_CFG_UART; endproperty
  a_mode: assert property (p_mode) else $error("uart mode not entered");
  property p_rx; !alt |-> serial_receive_input == sel; endproperty
  a_rx: assert property (p_rx) else $error("wrong receive pin");
  property p_uart;
    active_config == SPM_CFG_UART |->
      sport_rfs_in == serial_receive_input && gpio5_frame_sync_out == core_flag_output;
  endproperty
  a_uart: assert property (p_uart) else $error("uart routing wrong");
  property p_flag; alt |-> flag_input_pin == sel && transmit_pin_out == core_flag_output; endproperty
  a_flag: assert property (p_flag) else $error("flag routing wrong");
  property p_int;
    alt |-> core_external_int_a == receive_frame_sync_pin &&
      core_external_int_b == transmit_frame_sync_pin;
  endproperty
  a_int: assert property (p_int) else $error("interrupt routing wrong");
  property p_clk; sport_clock_in == serial_bit_clock_pin; endproperty
  a_clk: assert property (p_clk) else $error("bit clock lost");
  c_uart: cover property (active_config == SPM_CFG_UART);
  c_alt: cover property (alt && gpio_a_free);
  c_pin_b: cover property (gpio_a_free && !alt);
endmodule // spm_chk
bind spm_top spm_chk spm_chk_i (.*);

//--- verification/spm_partner.sv
`timescale 1ns/1ps
module spm_partner (
  input wire logic clock,
  input wire logic frame,
  input wire logic [3:0] pat,
  output logic receive_pin_a,
  output logic receive_pin_b,
  output logic receive_frame_sync_pin,
  output logic transmit_frame_sync_pin,
  output logic serial_bit_clock_pin
);
  logic sclk_reg = 1'h0;
  // Bit clock stands still between frames
  always @(posedge clock) sclk_reg <= frame ? ~sclk_reg : 1'h0;
  assign serial_bit_clock_pin = sclk_reg;
  assign {transmit_frame_sync_pin, receive_frame_sync_pin, receive_pin_b, receive_pin_a} = pat;
endmodule // spm_partner

//--- verification/spm_top_test.sv
`timescale 1ns/1ps
module spm_top_test;
  import spm_pkg::*;
  typedef struct {
    logic [1:0] m;
    logic alt;
    logic [3:0] pat;
    logic [2:0] cfg;
    logic [7:0] o;
  } spm_row_t;
  logic clock = '0, srst = '1, reg_write = '0, reg_read = '0, frame = '0;
  logic serial_transmit_output = '0, core_flag_output = '1, sport_rfs_out = '0, sport_rfs_oe = '1;
  logic receive_pin_a, receive_pin_b, receive_frame_sync_pin, transmit_frame_sync_pin;
  logic serial_bit_clock_pin, serial_receive_input, sport_rfs_in, sport_tfs_in, sport_clock_in;
  logic flag_input_pin, core_external_int_a, core_external_int_b, transmit_pin_out;
  logic gpio5_frame_sync_out, gpio5_frame_sync_oe, gpio_a_free, gpio_b_free;
  logic [3:0] pat = '0;
  spm_addr_t reg_addr = '0;
  spm_data_t reg_wdata = '0, reg_rdata;
  spm_cfg_t active_config;
  int error_cnt = 0, n_tests = 0;
  // Pins: rx, rfs in, flag in, tx pin, int a, int b, gpio5 out, gpio5 oe
  spm_row_t rows [6] = '{'{2'h0, 1'h0, 4'hd, 3'h1, 8'hcd}, '{2'h1, 1'h0, 4'h1, 3'h1, 8'h0d},
    '{2'h2, 1'h0, 4'h1, 3'h2, 8'hcf}, '{2'h3, 1'h0, 4'h5, 3'h2, 8'h0f},
    '{2'h0, 1'h1, 4'h9, 3'h4, 8'hf4}, '{2'h1, 1'h1, 4'h5, 3'h4, 8'hd8}};
  always #25 clock = ~clock;
  spm_partner spm_partner_i (.*);
  spm_top spm_top_i (.*);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge first, so a strobe never falls and rises in one time step
  task automatic wr(input spm_addr_t a, input spm_data_t d);
    @(posedge clock) #2;
    reg_addr = a;
    reg_wdata = d;
    reg_write = '1;
    @(posedge clock) #2 reg_write = '0;
  endtask
  task automatic rd(input spm_addr_t a, input spm_data_t exp);
    @(posedge clock) #2;
    reg_addr = a;
    reg_read = '1;
    @(posedge clock) #2 reg_read = '0;
    chk("rdata", reg_rdata, exp);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clock);
    #2 srst = '0;
    chk("cfg", active_config, SPM_CFG_NORMAL);
    rd(14'h2015, 16'h0000);
    rd(14'h3fff, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      pat = rows[i].pat;
      wr(14'h2015, {10'h0, rows[i].m, 4'h0});
      wr(14'h3fff, {5'h0, rows[i].alt, 10'h0});
      chk("cfg", {active_config, gpio_a_free, gpio_b_free},
        {rows[i].cfg, rows[i].m[0], !rows[i].m[0]});
      chk("pins", {serial_receive_input, sport_rfs_in, flag_input_pin, transmit_pin_out,
        core_external_int_a, core_external_int_b, gpio5_frame_sync_out, gpio5_frame_sync_oe},
        rows[i].o);
      chk("tfs", sport_tfs_in, rows[i].alt ? 1'h1 : rows[i].pat[3]);
      rd(14'h2015, {10'h0, rows[i].m, 4'h0});
    end
    // Unmapped words and upper mode bits must not stick
    wr(14'h2015, 16'hffff);
    rd(14'h2015, 16'h01ff);
    wr(14'h2014, 16'hffff);
    rd(14'h2014, 16'h0000);
    rd(14'h3fff, 16'h0400);
    core_flag_output = '0;
    @(posedge clock) #2 chk("flag", {gpio5_frame_sync_out, transmit_pin_out}, 2'h0);
    frame = '1;
    repeat (4) @(posedge clock) #2 chk("sclk", sport_clock_in, serial_bit_clock_pin);
    // Mid-run reset must drop every selection at once
    srst = '1;
    serial_transmit_output = '1;
    @(posedge clock) #2 srst = '0;
    chk("rst", {active_config, gpio_a_free, transmit_pin_out},
      {SPM_CFG_NORMAL, 2'h1});
    chk("rst_rx", serial_receive_input, receive_pin_a);
    rd(14'h2015, 16'h0000);
    test_done;
  end
endmodule // spm_top_test
